// ### hw/vga_addr_translate.sv
`timescale 1ns/1ps
`default_nettype none
module vga_addr_translate
   import vga_plane_pkg::*;
(
   // Byte address and direction.
   input wire logic [16:0] i_byte_addr,
   input wire logic i_is_write,
   // Address controls.
   input wire logic i_page_select_bit,
   input wire logic i_odd_even_chain,
   input wire logic i_force_addr_msb_low,
   input wire logic i_quad_chain_mode,
   input wire logic i_packed_quad_chain,
   input wire logic i_write_pair_chain,
   input wire logic i_read_pair_chain,
   input wire logic [1:0] i_read_plane_select,
   // Translated address and plane choice.
   output logic [15:0] o_lw_addr,
   output logic [3:0] o_plane_en,
   output logic [1:0] o_read_plane
);
   logic [16:0] addr;
   logic pair;

   // Modify the low bit and bit 15, then map by chaining mode.
   always_comb begin
      addr = i_byte_addr;
      // R17 page bit
      if (i_odd_even_chain) begin
         addr[0] = i_page_select_bit;
      end
      // R14 force bit fifteen
      if (i_force_addr_msb_low) begin
         addr[15] = 1'b0;
      end
      // R18 direction-specific pairing
      pair = i_is_write ? i_write_pair_chain : i_read_pair_chain;
      // R16 quad chain both ways
      if (i_quad_chain_mode) begin
         o_plane_en = 4'h1 << addr[1:0];
         o_read_plane = addr[1:0];
         // R15 packed shift
         o_lw_addr = i_packed_quad_chain ? {1'b0, addr[16:2]} : addr[15:0];
      end else if (pair) begin
         o_plane_en = addr[0] ? 4'ha : 4'h5;
         o_read_plane = {i_read_plane_select[1], addr[0]};
         o_lw_addr = addr[15:0];
      end else begin
         o_plane_en = 4'hf;
         // R13 plane select unchained
         o_read_plane = i_read_plane_select;
         o_lw_addr = addr[15:0];
      end
   end
endmodule
`default_nettype wire

// ### hw/vga_plane_memory_path.sv
`timescale 1ns/1ps
`default_nettype none
module vga_plane_memory_path
   import vga_plane_pkg::*;
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Register port, offset from the graphics register base.
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   output logic [31:0] o_reg_rdata,
   output logic o_reg_hit,
   // Processor memory access.
   input wire logic i_cpu_req,
   input wire logic i_cpu_we,
   input wire logic [19:0] i_cpu_addr,
   input wire logic [1:0] i_cpu_size,
   input wire logic [31:0] i_cpu_wdata,
   output logic o_cpu_busy,
   output logic o_cpu_done,
   output logic [31:0] o_cpu_rdata,
   // Graphics memory.
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [19:0] o_mem_addr,
   output logic [3:0] o_mem_wen,
   output logic [31:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata
);
   // ****************************************
   // State
   // ****************************************
   typedef enum logic [1:0] {PH_IDLE, PH_ISSUE, PH_WAIT} phase_t;
   typedef struct packed {
      phase_t ph;
      logic [31:0] wctl;
      logic [31:0] rctl;
      logic [5:0] mem_offset;
      logic [31:0] latch;
      logic [31:0] reg_rdata;
      logic req_we;
      logic [16:0] req_addr;
      logic [1:0] last;
      logic [1:0] idx;
      logic [31:0] req_wdata;
      logic [31:0] acc;
      logic mem_req;
      logic [19:0] mem_addr;
      logic [3:0] mem_wen;
      logic [31:0] mem_wdata;
      logic cpu_done;
      logic [31:0] cpu_rdata;
   } state_t;
   state_t s;
   state_t next_s;

   // ****************************************
   // Datapath functions
   // ****************************************
   // Selects one plane's byte from a four-plane word.
   function automatic logic [7:0] plane_byte(input logic [31:0] w, input logic [1:0] p);
      plane_byte = w[{p, 3'b000} +: 8];
   endfunction

   // Builds the four-plane write word from one processor byte.
   function automatic logic [31:0] write_word(input logic [31:0] ctl, input logic [7:0] d,
                                              input logic [31:0] held);
      logic [7:0] rot;
      logic [7:0] val;
      logic [7:0] m;
      logic [2:0] rc;
      rc = ctl[WC_ROT_LSB +: 3];
      // R10 byte rotator
      rot = 8'((({d, d}) >> rc));
      write_word = 32'h00000000;
      for (int p = 0; p < 4; p++) begin
         m = ctl[WC_BIT_MASK_LSB +: 8];
         if (ctl[WC_W3_BIT]) begin
            // R08 mask from rotated data
            val = {8{ctl[WC_FILL_VAL_LSB + p]}};
            m = m & rot;
         end else if (ctl[WC_W2_BIT]) begin
            // R09 data bits drive fill
            val = {8{d[p]}};
         end else begin
            // R25 R11 mode zero fill
            val = ctl[WC_FILL_EN_LSB + p] ? {8{ctl[WC_FILL_VAL_LSB + p]}} : rot;
         end
         // R12 mask merges held data
         write_word[p * 8 +: 8] = (val & m) | (held[p * 8 +: 8] & ~m);
      end
   endfunction

   // Reduces a four-plane word to one returned byte.
   function automatic logic [7:0] read_byte(input logic [31:0] ctl, input logic [31:0] w,
                                            input logic [1:0] plane);
      logic [7:0] r;
      r = 8'hff;
      // R19 read mode choice
      if (ctl[RC_COMPARE_BIT]) begin
         // R20 masked colour compare
         for (int p = 0; p < 4; p++) begin
            if (ctl[RC_CMASK_LSB + p]) begin
               r = r & ~(plane_byte(w, 2'(p)) ^ {8{ctl[RC_CCOLOR_LSB + p]}});
            end
         end
      end else begin
         r = plane_byte(w, plane);
      end
      read_byte = r;
   endfunction

   // ****************************************
   // Address translation
   // ****************************************
   logic [16:0] byte_addr;
   logic [7:0] cur_byte;
   logic [15:0] lw_addr;
   logic [3:0] plane_en;
   logic [1:0] read_plane;
   logic [7:0] rd_byte;
   logic reg_in_win;
   logic [15:0] reg_rel;

   // R21 sequencer makes low bits
   assign byte_addr = s.req_addr + {15'h0000, s.idx};
   assign cur_byte = s.req_wdata[{s.idx, 3'b000} +: 8];
   // R23 word to byte
   assign rd_byte = read_byte(s.rctl, i_mem_rdata, read_plane);
   assign reg_rel = i_reg_addr - REG_WIN_BASE;
   // R01 register window decode
   assign reg_in_win = (i_reg_addr >= REG_WIN_BASE) && (reg_rel < REG_WIN_SIZE);

   vga_addr_translate u_addr (
      .i_byte_addr(byte_addr),
      .i_is_write(s.req_we),
      .i_page_select_bit(s.rctl[RC_PAGE_BIT]),
      .i_odd_even_chain(s.rctl[RC_ODD_EVEN_BIT]),
      .i_force_addr_msb_low(s.rctl[RC_F15_BIT]),
      .i_quad_chain_mode(s.rctl[RC_QUAD_BIT]),
      .i_packed_quad_chain(s.rctl[RC_PACKED_BIT]),
      .i_write_pair_chain(s.rctl[RC_WPAIR_BIT]),
      .i_read_pair_chain(s.rctl[RC_RPAIR_BIT]),
      .i_read_plane_select(s.rctl[RC_PLANE_LSB +: 2]),
      .o_lw_addr(lw_addr),
      .o_plane_en(plane_en),
      .o_read_plane(read_plane)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s = s;
      next_s.cpu_done = 1'b0;
      // Register writes keep only implemented bits.
      if (i_reg_wr) begin
         case (i_reg_addr)
            OFF_WRITE_CTL: next_s.wctl = i_reg_wdata & WRITE_CTL_MASK;
            OFF_READ_CTL: next_s.rctl = i_reg_wdata & READ_CTL_MASK;
            // R02 offset from low bits
            OFF_MEM_OFFSET: next_s.mem_offset = i_reg_wdata[OFFS_WR_LSB +: OFFS_W];
            // R05 software loads latch
            OFF_HOLDING: next_s.latch = i_reg_wdata;
            default: next_s.wctl = s.wctl;
         endcase
      end
      // Register reads return registered data, zero when unmapped.
      if (i_reg_rd) begin
         case (i_reg_addr)
            OFF_WRITE_CTL: next_s.reg_rdata = s.wctl;
            OFF_READ_CTL: next_s.reg_rdata = s.rctl;
            // R03 offset reads at 13:8
            OFF_MEM_OFFSET: next_s.reg_rdata = 32'(s.mem_offset) << OFFS_RD_LSB;
            OFF_HOLDING: next_s.reg_rdata = s.latch;
            default: next_s.reg_rdata = 32'h00000000;
         endcase
      end
      case (s.ph)
         PH_IDLE: begin
            if (i_cpu_req) begin
               // R24 only the VGA range
               if (i_cpu_addr[19:17] == VGA_RANGE_TAG) begin
                  next_s.ph = PH_ISSUE;
                  next_s.req_we = i_cpu_we;
                  next_s.req_addr = i_cpu_addr[16:0];
                  next_s.req_wdata = i_cpu_wdata;
                  next_s.idx = 2'h0;
                  next_s.acc = 32'h00000000;
                  next_s.last = (i_cpu_size == SIZE_BYTE) ? 2'h0 : ((i_cpu_size == SIZE_WORD) ? 2'h1 : 2'h3);
               end else begin
                  next_s.cpu_done = 1'b1;
                  next_s.cpu_rdata = 32'h00000000;
               end
            end
         end
         PH_ISSUE: begin
            next_s.ph = PH_WAIT;
            next_s.mem_req = 1'b1;
            // R04 offset added to address
            next_s.mem_addr = {s.mem_offset, 14'h0000} + {4'h0, lw_addr};
            // R07 enables with chaining
            next_s.mem_wen = s.req_we ? (s.wctl[WC_MAP_MASK_LSB +: 4] & plane_en) : 4'h0;
            // R22 byte to word write
            next_s.mem_wdata = write_word(s.wctl, cur_byte, s.latch);
         end
         PH_WAIT: begin
            if (i_mem_ack) begin
               next_s.mem_req = 1'b0;
               if (!s.req_we) begin
                  // R06 reads load latch
                  next_s.latch = i_mem_rdata;
                  next_s.acc[{s.idx, 3'b000} +: 8] = rd_byte;
               end
               if (s.idx == s.last) begin
                  next_s.ph = PH_IDLE;
                  next_s.cpu_done = 1'b1;
                  next_s.cpu_rdata = next_s.acc;
               end else begin
                  next_s.ph = PH_ISSUE;
                  next_s.idx = s.idx + 2'h1;
               end
            end
         end
         default: begin
            next_s.ph = PH_IDLE;
         end
      endcase
   end

   // Registers the whole state.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s <= '0;
         s.ph <= PH_IDLE;
         s.wctl <= WRITE_CTL_RST;
         s.rctl <= READ_CTL_RST;
         s.mem_offset <= MEM_OFFSET_RST;
         s.latch <= HOLDING_RST;
      end else begin
         s <= next_s;
      end
   end

   // Drives the ports.
   assign o_reg_rdata = s.reg_rdata;
   assign o_reg_hit = reg_in_win;
   assign o_cpu_busy = (s.ph != PH_IDLE);
   assign o_cpu_done = s.cpu_done;
   assign o_cpu_rdata = s.cpu_rdata;
   assign o_mem_req = s.mem_req;
   assign o_mem_we = s.req_we;
   assign o_mem_addr = s.mem_addr;
   assign o_mem_wen = s.mem_wen;
   assign o_mem_wdata = s.mem_wdata;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   // Request level one cycle back; a rising request marks the first cycle of a memory access.
   logic prev_mem_req;
   logic new_req;
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         prev_mem_req <= 1'b0;
      end else begin
         prev_mem_req <= o_mem_req;
      end
   end
   assign new_req = o_mem_req && !prev_mem_req;

   // Register port, holding word, plane enable and address bit 15 checks.
   a_offset_readback: assert property ( // R02 R03
      (i_reg_wr && i_reg_addr == OFF_MEM_OFFSET) ##1 !i_reg_wr
      ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == OFF_MEM_OFFSET)
      |=> o_reg_rdata == (32'($past(i_reg_wdata[5:0], 3)) << 8))
      else $error("offset readback wrong");
   a_holding_write: assert property ( // R05
      i_reg_wr && i_reg_addr == OFF_HOLDING && !(s.ph == PH_WAIT && i_mem_ack && !s.req_we)
      |=> s.latch == $past(i_reg_wdata))
      else $error("holding word write lost");
   a_unmapped_zero: assert property ( // R01
      i_reg_rd && !reg_in_win |=> o_reg_rdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_latch_load: assert property ( // R06
      s.ph == PH_WAIT && i_mem_ack && !s.req_we |=> s.latch == $past(i_mem_rdata))
      else $error("latch not loaded by read");
   a_wen_masked: assert property ( // R07
      o_mem_req && o_mem_we |-> (o_mem_wen & ~s.wctl[27:24]) == 4'h0)
      else $error("plane enable outside mask");
   a_msb_forced: assert property ( // R14
      new_req && s.rctl[15] && !s.rctl[13] |-> ((o_mem_addr - {s.mem_offset, 14'h0000}) & 20'h08000) == 20'h00000)
      else $error("address bit 15 not forced");

   // Write path, compare read and range checks.
   a_fill_mode0: assert property ( // R11
      new_req && o_mem_we && s.wctl[20:19] == 2'b00 && s.wctl[15:12] == 4'hf && s.wctl[7:0] == 8'hff
      |-> o_mem_wdata == {{8{s.wctl[11]}}, {8{s.wctl[10]}}, {8{s.wctl[9]}}, {8{s.wctl[8]}}})
      else $error("fill value not written");
   a_mode2_data: assert property ( // R09
      new_req && o_mem_we && s.wctl[20:19] == 2'b01 && s.wctl[7:0] == 8'hff |-> o_mem_wdata[7:0] == {8{cur_byte[0]}})
      else $error("write mode two data wrong");
   a_mask_keeps: assert property ( // R12
      new_req && o_mem_we && !s.wctl[20] && s.wctl[7:0] == 8'h00 |-> o_mem_wdata == s.latch)
      else $error("zero mask altered held data");
   a_rotate_one: assert property ( // R10
      new_req && o_mem_we && s.wctl[20:12] == 9'h010 && s.wctl[7:0] == 8'hff
      |-> o_mem_wdata[7:0] == {cur_byte[0], cur_byte[7:1]})
      else $error("rotate by one wrong");
   a_compare_none: assert property ( // R20
      s.ph == PH_WAIT && i_mem_ack && !s.req_we && s.rctl[8] && s.rctl[7:4] == 4'h0 |-> rd_byte == 8'hff)
      else $error("empty compare not all ones");
   a_range_reject: assert property ( // R24
      s.ph == PH_IDLE && i_cpu_req && i_cpu_addr[19:17] != 3'h5 |=> o_cpu_done && !o_cpu_busy && o_cpu_rdata == 32'h0)
      else $error("out of range access handled");

   // Address translation and memory request checks.
   a_read_no_wen: assert property ( // R07
      o_mem_req && !o_mem_we |-> o_mem_wen == 4'h0)
      else $error("plane enable on a read");
   a_req_stable: assert property ( // R22
      o_mem_req && !i_mem_ack
      |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wen) && $stable(o_mem_wdata))
      else $error("memory request changed before answer");
   a_odd_even_bit: assert property ( // R17
      new_req && s.rctl[11] && !s.rctl[14] |-> o_mem_addr[0] == s.rctl[12])
      else $error("page bit not in address bit 0");
   a_quad_plane: assert property ( // R16
      new_req && o_mem_we && s.rctl[13] && !s.rctl[11] |-> (o_mem_wen & ~(4'h1 << byte_addr[1:0])) == 4'h0)
      else $error("quad chain enabled a wrong plane");

   // Scenario coverage.
   c_dword_write: cover property (s.ph == PH_WAIT && s.req_we && s.last == 2'h3 && i_mem_ack && s.idx == 2'h3);
   c_compare_read: cover property (o_cpu_done && s.rctl[8] && !s.req_we);
   c_quad_write: cover property (new_req && o_mem_we && s.rctl[13]);
   c_pair_read: cover property (o_cpu_done && !s.req_we && s.rctl[9]);
   c_fill_write: cover property (new_req && o_mem_we && s.wctl[15:12] != 4'h0);
endmodule
`default_nettype wire

// ### hw/vga_plane_pkg.sv
// Summary of operation
// R01 - Decode 200h locations from offset 8100h.
// R02 - Offset write takes bits 5:0.
// R03 - Offset read returns it in 13:8.
// R04 - Offset added at any 64 KB boundary.
// R05 - Holding word readable and writable by software.
// R06 - Reads load holding word; writes reuse it.
// R07 - Plane write enables combine with chaining.
// R08 - Bit 20 selects write mode three.
// R09 - Bit 19 selects write mode two.
// R10 - Field 18:16 rotates each incoming byte.
// R11 - Per-plane fill enable and fill value.
// R12 - Bit mask picks new or held data.
// R13 - Plane select used only without chaining; the code still uses its bit 1 with pair chaining.
// R14 - Bit 15 forces address bit 15 low.
// R15 - Packed quad chain shifts address right two.
// R16 - Bit 13 selects quad chain both ways.
// R17 - Page select bit replaces address bit 0.
// R18 - Separate pair chaining for writes, reads.
// R19 - Bit 8 selects colour compare reads.
// R20 - Compare mask and compare colour fields.
// R21 - Multibyte accesses split into byte operations.
// R22 - Each byte write becomes one word write.
// R23 - Each word read yields one byte.
// R24 - Only A0000h to BFFFFh is handled.
// R25 - Default write mode zero uses fill, mask.
// R26 - Software writes zero to reserved bits.
package vga_plane_pkg;
   // ****************************************
   // Register window and offsets
   // ****************************************
   localparam logic [15:0] REG_WIN_BASE = 16'h8100;
   localparam logic [15:0] REG_WIN_SIZE = 16'h0200;
   localparam logic [15:0] OFF_WRITE_CTL = 16'h8140;
   localparam logic [15:0] OFF_READ_CTL = 16'h8144;
   localparam logic [15:0] OFF_MEM_OFFSET = 16'h8210;
   localparam logic [15:0] OFF_HOLDING = 16'h8214;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int WC_MAP_MASK_LSB = 24;
   localparam int WC_W3_BIT = 20;
   localparam int WC_W2_BIT = 19;
   localparam int WC_ROT_LSB = 16;
   localparam int WC_FILL_EN_LSB = 12;
   localparam int WC_FILL_VAL_LSB = 8;
   localparam int WC_BIT_MASK_LSB = 0;
   localparam int RC_PLANE_LSB = 16;
   localparam int RC_F15_BIT = 15;
   localparam int RC_PACKED_BIT = 14;
   localparam int RC_QUAD_BIT = 13;
   localparam int RC_PAGE_BIT = 12;
   localparam int RC_ODD_EVEN_BIT = 11;
   localparam int RC_WPAIR_BIT = 10;
   localparam int RC_RPAIR_BIT = 9;
   localparam int RC_COMPARE_BIT = 8;
   localparam int RC_CMASK_LSB = 4;
   localparam int RC_CCOLOR_LSB = 0;
   localparam int OFFS_WR_LSB = 0;
   localparam int OFFS_RD_LSB = 8;
   localparam int OFFS_W = 6;
   localparam int MEM_OFFS_LSB = 14;
   // ****************************************
   // Implemented bits and reset values
   // ****************************************
   localparam logic [31:0] WRITE_CTL_MASK = 32'h0f1fffff;
   localparam logic [31:0] READ_CTL_MASK = 32'h0003ffff;
   localparam logic [31:0] WRITE_CTL_RST = 32'h00000000;
   localparam logic [31:0] READ_CTL_RST = 32'h00000000;
   localparam logic [5:0] MEM_OFFSET_RST = 6'h00;
   localparam logic [31:0] HOLDING_RST = 32'h00000000;
   // ****************************************
   // Processor side
   // ****************************************
   localparam logic [2:0] VGA_RANGE_TAG = 3'h5;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
endpackage

// ### tb/vga_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module vga_mem_model (
   // Clock, reset and answer delay.
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_delay,
   // Memory request from the block.
   input wire logic i_mem_req,
   input wire logic i_mem_we,
   input wire logic [19:0] i_mem_addr,
   input wire logic [3:0] i_mem_wen,
   input wire logic [31:0] i_mem_wdata,
   // Answer and record of the last access.
   output logic o_mem_ack,
   output logic [31:0] o_mem_rdata,
   output logic [19:0] o_last_addr,
   output logic [3:0] o_last_wen,
   output logic [31:0] o_last_wdata,
   output var int o_count
);
   logic [31:0] mem [logic [19:0]];
   logic [31:0] word;
   logic [3:0] wait_cnt;
   // Answers one access after the chosen delay; read data is inverted once released.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_mem_ack <= 1'b0;
         o_mem_rdata <= 32'h0;
         wait_cnt <= 4'h0;
         o_count <= 0;
      end else if (o_mem_ack) begin
         o_mem_ack <= 1'b0;
         o_mem_rdata <= ~o_mem_rdata;
      end else if (i_mem_req && wait_cnt < i_delay) begin
         wait_cnt <= wait_cnt + 4'h1;
      end else if (i_mem_req) begin
         word = mem.exists(i_mem_addr) ? mem[i_mem_addr] : 32'h0;
         for (int p = 0; p < 4; p++) begin
            if (i_mem_we && i_mem_wen[p]) begin
               word[8*p+:8] = i_mem_wdata[8*p+:8];
            end
         end
         mem[i_mem_addr] = word;
         o_mem_ack <= 1'b1;
         o_mem_rdata <= word;
         wait_cnt <= 4'h0;
         o_count <= o_count + 1;
         o_last_addr <= i_mem_addr;
         o_last_wen <= i_mem_wen;
         o_last_wdata <= i_mem_wdata;
      end
   end
endmodule
`default_nettype wire

// ### tb/vga_plane_memory_path_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vga_plane_memory_path_tb_top;
   logic core_clk, rst, reg_wr, reg_rd, reg_hit, cpu_req, cpu_we, cpu_busy, cpu_done;
   logic mem_req, mem_we, mem_ack;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, cpu_wdata, cpu_rdata, mem_wdata, mem_rdata, last_wdata, x;
   logic [19:0] cpu_addr, mem_addr, last_addr;
   logic [1:0] cpu_size;
   logic [3:0] mem_wen, last_wen, mem_delay;
   int mem_count, errors, n_checks, c0;
   logic [15:0] hit_addr [4] = '{16'h8100, 16'h82ff, 16'h80ff, 16'h8300};
   logic hit_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

   vga_plane_memory_path dut (.i_core_clk(core_clk), .i_rst(rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_hit(reg_hit),
      .i_cpu_req(cpu_req), .i_cpu_we(cpu_we), .i_cpu_addr(cpu_addr), .i_cpu_size(cpu_size),
      .i_cpu_wdata(cpu_wdata), .o_cpu_busy(cpu_busy), .o_cpu_done(cpu_done), .o_cpu_rdata(cpu_rdata),
      .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_wen(mem_wen),
      .o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata));
   vga_mem_model mem (.i_core_clk(core_clk), .i_rst(rst), .i_delay(mem_delay), .i_mem_req(mem_req),
      .i_mem_we(mem_we), .i_mem_addr(mem_addr), .i_mem_wen(mem_wen), .i_mem_wdata(mem_wdata),
      .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata), .o_last_addr(last_addr), .o_last_wen(last_wen),
      .o_last_wdata(last_wdata), .o_count(mem_count));

   // ****************************************
   // Checking and closing tasks
   // ****************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ****************************************
   // Access tasks
   // ****************************************
   // Register writes keep reserved bits at zero.
   task automatic rw(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk);
      #2;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge core_clk);
      #2;
      reg_wr = 1'b0;
   endtask
   task automatic rchk(input logic [15:0] a, input logic [31:0] e);
      @(posedge core_clk);
      #2;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge core_clk);
      #2;
      reg_rd = 1'b0;
      chk($sformatf("reg %h", a), e, reg_rdata);
   endtask
   // Raises the request for one cycle, then waits up to 200 cycles for the done pulse.
   task automatic cpu(input logic we, input logic [19:0] a, input logic [1:0] sz, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      #2;
      cpu_req = 1'b1;
      cpu_we = we;
      cpu_addr = a;
      cpu_size = sz;
      cpu_wdata = d;
      @(posedge core_clk);
      #2;
      cpu_req = 1'b0;
      chk("cpu_busy", {31'h0, a[19:17] == 3'h5}, {31'h0, cpu_busy});
      k = 0;
      while (cpu_done !== 1'b1 && k < 200) begin
         @(posedge core_clk);
         #2;
         k++;
      end
      chk("cpu_done", 32'h1, {31'h0, cpu_done});
      x = cpu_rdata;
   endtask
   task automatic wcase(input logic [31:0] wc, input logic [31:0] rc, input logic [16:0] b,
      input logic [7:0] d, input logic [19:0] ea, input logic [3:0] ew, input logic [31:0] ed);
      rw(16'h8140, wc);
      rw(16'h8144, rc);
      cpu(1'b1, {3'h5, b}, 2'h0, {24'h0, d});
      if (ea !== 20'hfffff) chk("mem_addr", {12'h0, ea}, {12'h0, last_addr});
      chk("mem_wen", {28'h0, ew}, {28'h0, last_wen});
      chk("mem_wdata", ed, last_wdata);
   endtask
   task automatic rcase(input logic [31:0] rc, input logic [16:0] b, input logic [7:0] e);
      rw(16'h8144, rc);
      cpu(1'b0, {3'h5, b}, 2'h0, 32'h0);
      chk("cpu_rdata", {24'h0, e}, {24'h0, x[7:0]});
   endtask

   // Clock at 40 MHz.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Cuts a hang short.
   initial begin
      #250000;
      errors++;
      results();
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, cpu_req, cpu_we} = 4'h0;
      reg_addr = 16'h0;
      reg_wdata = 32'h0;
      cpu_addr = 20'h0;
      cpu_size = 2'h0;
      cpu_wdata = 32'h0;
      mem_delay = 4'h0;
      repeat (5) @(posedge core_clk);
      #2;
      rst = 1'b0;
      foreach (hit_addr[i]) begin
         @(posedge core_clk);
         #2;
         reg_addr = hit_addr[i];
         #1;
         chk("reg_hit", {31'h0, hit_exp[i]}, {31'h0, reg_hit});
      end
      rchk(16'h8140, 32'h0);
      rchk(16'h8144, 32'h0);
      rchk(16'h8210, 32'h0);
      rchk(16'h8214, 32'h0);
      rw(16'h8300, 32'hffffffff);
      rchk(16'h8300, 32'h0);
      rw(16'h8140, 32'h0f1fffff);
      rchk(16'h8140, 32'h0f1fffff);
      rw(16'h8144, 32'h0003ffff);
      rchk(16'h8144, 32'h0003ffff);
      rw(16'h8210, 32'h0000003f);
      rchk(16'h8210, 32'h00003f00);
      rw(16'h8214, 32'h12345678);
      rchk(16'h8214, 32'h12345678);
      rw(16'h8210, 32'h00000002);
      rw(16'h8214, 32'haaaaaaaa);
      // Write path cases at memory offset 2, byte planes 3..0.
      wcase(32'h0f0000ff, 32'h0, 17'h4, 8'h5a, 20'h08004, 4'hf, 32'h5a5a5a5a);
      wcase(32'h0f0100ff, 32'h0, 17'h4, 8'h01, 20'h08004, 4'hf, 32'h80808080);
      wcase(32'h0f00f5ff, 32'h0, 17'h4, 8'h00, 20'h08004, 4'hf, 32'h00ff00ff);
      wcase(32'h0f00000f, 32'h0, 17'h4, 8'hff, 20'h08004, 4'hf, 32'hafafafaf);
      wcase(32'h0f000000, 32'h0, 17'h4, 8'h5a, 20'h08004, 4'hf, 32'haaaaaaaa);
      wcase(32'h0f0800ff, 32'h0, 17'h4, 8'h0a, 20'h08004, 4'hf, 32'hff00ff00);
      wcase(32'h0f1005ff, 32'h0, 17'h4, 8'h0f, 20'h08004, 4'hf, 32'ha0afa0af);
      wcase(32'h030000ff, 32'h0, 17'h4, 8'h5a, 20'h08004, 4'h3, 32'h5a5a5a5a);
      wcase(32'h0f0000ff, 32'h2000, 17'h6, 8'h5a, 20'h08006, 4'h4, 32'h5a5a5a5a);
      wcase(32'h0f0000ff, 32'h6000, 17'h6, 8'h5a, 20'h08001, 4'h4, 32'h5a5a5a5a);
      wcase(32'h0f0000ff, 32'h8000, 17'h8004, 8'h5a, 20'h08004, 4'hf, 32'h5a5a5a5a);
      wcase(32'h0f0000ff, 32'h1800, 17'h4, 8'h5a, 20'h08005, 4'hf, 32'h5a5a5a5a);
      wcase(32'h0f0000ff, 32'h0400, 17'h3, 8'h5a, 20'h08003, 4'ha, 32'h5a5a5a5a);
      wcase(32'h0f0055ff, 32'h0, 17'h10, 8'h3c, 20'h08010, 4'hf, 32'h3cff3cff);
      // Read path, with a slow memory on the first two plane reads.
      mem_delay = 4'h3;
      rcase(32'h10000, 17'h10, 8'h3c);
      rcase(32'h20000, 17'h10, 8'hff);
      rchk(16'h8214, 32'h3cff3cff);
      mem_delay = 4'h0;
      rcase(32'h01f5, 17'h10, 8'hc3);
      rcase(32'h0115, 17'h10, 8'hff);
      rcase(32'h0100, 17'h10, 8'hff);
      rcase(32'h30200, 17'h10, 8'hff);
      // Multibyte accesses go out as one memory cycle per byte.
      rw(16'h8140, 32'h0f0000ff);
      rw(16'h8144, 32'h10000);
      c0 = mem_count;
      cpu(1'b1, 20'ha0020, 2'h1, 32'h0000bbaa);
      chk("mem_count", c0 + 2, mem_count);
      chk("mem_addr", 32'h08021, {12'h0, last_addr});
      chk("mem_wdata", 32'hbbbbbbbb, last_wdata);
      cpu(1'b0, 20'ha0010, 2'h2, 32'h0);
      chk("cpu_rdata", 32'h0000003c, x);
      // Outside the window no memory cycle is made.
      c0 = mem_count;
      cpu(1'b0, 20'h90010, 2'h0, 32'h0);
      chk("cpu_rdata", 32'h0, x);
      chk("mem_count", c0, mem_count);
      results();
   end
endmodule
`default_nettype wire
